// [src/gpio_output_mux_pkg.sv]
// Purpose: constants for the pin 1 output multiplexer and driver control
// Assumes: one 8-bit control register on a plain strobe port
// Notes: source and select codes follow the control register layout
// How it works
// - Source bits 4:2 pick receive port 0-3 (000-011), status (100) or transmit port (110).
// - Source codes 101 and 111 are reserved and drive a defined low level.
// - Select field bits 7:5 picks the signal within the group and both fields reset to zero.
// - Receive-port select 000 drives remote pin 0 and 011 drives remote pin 3.
// - Receive-port select 100 drives link lock and 101 drives pass.
// - Receive-port select 110 drives frame valid and 111 drives line valid.
// - Device-status select 000 drives the register level bit.
// - Device-status select 001 drives OR of lock over enabled ports and 010 their AND.
// - Device-status selects 101 to 111 are reserved and drive low.
// - Transmit select 000 drives AND of selected ports' pass and 001 their OR.
// - Transmit select 011 is high while a video line is being sent.
// - Transmit select 100 shows multi-port sync, 101 the transmit interrupt, 111 is reserved.
// - Bit 1 holds the software level driven in register-level mode and resets to 0.
// - Bit 0 enables the pin driver when 1 and resets to 0 so the pin floats after reset.
package gpio_output_mux_pkg;
  localparam logic [7:0] pin1_output_control_addr = 8'h11;
  localparam logic [7:0] pin1_output_control_rst = 8'h00;
  localparam int sel_lsb = 5;
  localparam int src_lsb = 2;
  localparam int level_bit = 1;
  localparam int enable_bit = 0;
  localparam logic [2:0] src_status = 3'h4;
  localparam logic [2:0] src_tx = 3'h6;
  localparam logic [2:0] sel_rx_lock = 3'h4;
  localparam logic [2:0] sel_rx_pass = 3'h5;
  localparam logic [2:0] sel_rx_fv = 3'h6;
  localparam logic [2:0] sel_rx_lv = 3'h7;
  localparam logic [2:0] sel_st_level = 3'h0;
  localparam logic [2:0] sel_st_lock_or = 3'h1;
  localparam logic [2:0] sel_st_lock_and = 3'h2;
  localparam logic [2:0] sel_st_pass_and = 3'h3;
  localparam logic [2:0] sel_st_fsync = 3'h4;
  localparam logic [2:0] sel_tx_pass_and = 3'h0;
  localparam logic [2:0] sel_tx_pass_or = 3'h1;
  localparam logic [2:0] sel_tx_frame = 3'h2;
  localparam logic [2:0] sel_tx_line = 3'h3;
  localparam logic [2:0] sel_tx_sync = 3'h4;
  localparam logic [2:0] sel_tx_irq = 3'h5;
endpackage

// [src/port_reduce.sv]
// Purpose: AND and OR of a status vector over a set of enabled ports
// Assumes: an empty enable set gives AND low and OR low
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module port_reduce #(
  parameter int N = 4
) (
  // inputs
  input wire logic [N-1:0] status,
  input wire logic [N-1:0] enable,
  // results
  output logic any_set,
  output logic all_set
);
  // an empty set must not report all set, so AND is qualified by any enable
  assign any_set = |(status & enable);
  assign all_set = (|enable) && (&(status | ~enable));
endmodule
`default_nettype wire

// [src/rx_signal_pick.sv]
// Purpose: pick one of eight signals of one receive port by select code
// Assumes: select code is the register's select field
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module rx_signal_pick
  import gpio_output_mux_pkg::*;
(
  // port signals
  input wire logic [3:0] remote_pin,
  input wire logic lock,
  input wire logic pass,
  input wire logic frame_valid,
  input wire logic line_valid,
  // select and result
  input wire logic [2:0] sel,
  output logic picked
);
  // codes 000..011 index the remote pins directly
  always_comb begin
    unique case (sel)
      sel_rx_lock: picked = lock;
      sel_rx_pass: picked = pass;
      sel_rx_fv: picked = frame_valid;
      sel_rx_lv: picked = line_valid;
      default: picked = remote_pin[sel[1:0]];
    endcase
  end
endmodule
`default_nettype wire

// [src/gpio_output_mux.sv]
// Purpose: output multiplexer and driver control for general-purpose pin 1
// Assumes: all routed status inputs are synchronous to clock
// Notes: pin output and enable are registered, adding one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module gpio_output_mux
  import gpio_output_mux_pkg::*;
#(
  parameter int PORTS = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // receive port signals, four remote pins per port
  input wire logic [4*PORTS-1:0] rx_remote_pin,
  input wire logic [PORTS-1:0] rx_lock,
  input wire logic [PORTS-1:0] rx_pass,
  input wire logic [PORTS-1:0] rx_frame_valid,
  input wire logic [PORTS-1:0] rx_line_valid,
  input wire logic [PORTS-1:0] rx_port_enabled,
  // transmit port and device signals
  input wire logic [PORTS-1:0] tx_port_selected,
  input wire logic tx_frame_active,
  input wire logic tx_line_active,
  input wire logic tx_synchronized,
  input wire logic tx_interrupt,
  input wire logic frame_sync_pulse,
  // pin
  output logic pin1_out,
  output logic pin1_oe_b
);
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic out_r, out_nxt;
  logic oe_b_r, oe_b_nxt;
  logic [2:0] pin1_signal_select;
  logic [2:0] pin1_source_group;
  logic pin1_register_level;
  logic pin1_drive_enable;
  logic [PORTS-1:0] rx_pick;
  logic lock_or, lock_and, pass_en_or, pass_en_and, pass_tx_or, pass_tx_and;
  logic status_sig, tx_sig, route;

  // field split of the control register
  assign pin1_signal_select = ctl_r[sel_lsb +: 3];
  assign pin1_source_group = ctl_r[src_lsb +: 3];
  assign pin1_register_level = ctl_r[level_bit];
  assign pin1_drive_enable = ctl_r[enable_bit];

  // one picker per receive port, all sharing the select field
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_rx
      rx_signal_pick u_pick (
        .remote_pin(rx_remote_pin[4*g +: 4]),
        .lock(rx_lock[g]),
        .pass(rx_pass[g]),
        .frame_valid(rx_frame_valid[g]),
        .line_valid(rx_line_valid[g]),
        .sel(pin1_signal_select),
        .picked(rx_pick[g])
      );
    end
  endgenerate

  // reductions over enabled ports for status and over selected ports for transmit
  port_reduce #(.N(PORTS)) u_lock_en (
    .status(rx_lock),
    .enable(rx_port_enabled),
    .any_set(lock_or),
    .all_set(lock_and)
  );
  port_reduce #(.N(PORTS)) u_pass_en (
    .status(rx_pass),
    .enable(rx_port_enabled),
    .any_set(pass_en_or),
    .all_set(pass_en_and)
  );
  port_reduce #(.N(PORTS)) u_pass_tx (
    .status(rx_pass),
    .enable(tx_port_selected),
    .any_set(pass_tx_or),
    .all_set(pass_tx_and)
  );

  // device status group; reserved codes hold the pin low
  always_comb begin
    unique case (pin1_signal_select)
      sel_st_level: status_sig = pin1_register_level;
      sel_st_lock_or: status_sig = lock_or;
      sel_st_lock_and: status_sig = lock_and;
      sel_st_pass_and: status_sig = pass_en_and;
      sel_st_fsync: status_sig = frame_sync_pulse;
      default: status_sig = 1'b0;
    endcase
  end

  // transmit port group; 110 and 111 are reserved and read low
  always_comb begin
    unique case (pin1_signal_select)
      sel_tx_pass_and: tx_sig = pass_tx_and;
      sel_tx_pass_or: tx_sig = pass_tx_or;
      sel_tx_frame: tx_sig = tx_frame_active;
      sel_tx_line: tx_sig = tx_line_active;
      sel_tx_sync: tx_sig = tx_synchronized;
      sel_tx_irq: tx_sig = tx_interrupt;
      default: tx_sig = 1'b0;
    endcase
  end

  // source group choice; reserved sources give a quiet low rather than garbage
  always_comb begin
    route = 1'b0;
    if (pin1_source_group[2] == 1'b0) begin
      route = rx_pick[pin1_source_group[1:0]];
    end else if (pin1_source_group == src_status) begin
      route = status_sig;
    end else if (pin1_source_group == src_tx) begin
      route = tx_sig;
    end
  end

  // register writes and read data, read data valid the cycle after the strobe
  always_comb begin
    ctl_nxt = ctl_r;
    rdata_nxt = 8'h00;
    if (reg_write && reg_addr == pin1_output_control_addr) begin
      ctl_nxt = reg_wdata;
    end
    if (reg_read && reg_addr == pin1_output_control_addr) begin
      rdata_nxt = ctl_r;
    end
  end

  // pin level and driver; the enable is active low at the pin
  always_comb begin
    out_nxt = route;
    oe_b_nxt = ~pin1_drive_enable;
  end

  // registers; driver off and all fields zero after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= pin1_output_control_rst;
      rdata_r <= 8'h00;
      out_r <= 1'b0;
      oe_b_r <= 1'b1;
    end else begin
      ctl_r <= ctl_nxt;
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pin1_out = out_r;
  assign pin1_oe_b = oe_b_r;
endmodule
`default_nettype wire

// [testbench/gpio_output_mux_checker.sv]
// Purpose: concurrent checks on pin 1 routing and the control register
// Assumes: bound to the multiplexer top, four receive ports
// Notes: a shadow of the control register is rebuilt from bus writes
`timescale 1ns/1ps
`default_nettype none
module gpio_output_mux_checker
  import gpio_output_mux_pkg::*;
#(
  parameter int PORTS = 4
) (
  // clock, reset and register port
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // routed inputs and pin
  input wire logic [4*PORTS-1:0] rx_remote_pin,
  input wire logic [PORTS-1:0] rx_lock,
  input wire logic [PORTS-1:0] rx_pass,
  input wire logic [PORTS-1:0] tx_port_selected,
  input wire logic tx_line_active,
  input wire logic pin1_out,
  input wire logic pin1_oe_b
);
  logic [7:0] ctl_r, ctl_nxt;
  logic [2:0] src, sel;
  logic run_r;
  // shadow register, so routing is judged against what software wrote
  always_comb ctl_nxt = (reg_write && reg_addr == 8'h11) ? reg_wdata : ctl_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 8'h00;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end
  // checks start one edge after release; the releasing edge still loads reset values
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
    end
  end
  assign src = ctl_r[4:2];
  assign sel = ctl_r[7:5];
  default clocking @(posedge clock); endclocking
  default disable iff (!run_r);
  // pin follows the sampled selection and inputs one cycle later
  property p_pin; src < 4 && sel < 4 |=> pin1_out == $past(rx_remote_pin[4*src+sel]); endproperty
  a_pin: assert property (p_pin) else $error("remote pin not routed");
  property p_lock; src < 4 && sel == 4 |=> pin1_out == $past(rx_lock[src[1:0]]); endproperty
  a_lock: assert property (p_lock) else $error("lock not routed");
  property p_lvl; src == 4 && sel == 0 |=> pin1_out == $past(ctl_r[1]); endproperty
  a_lvl: assert property (p_lvl) else $error("level bit not routed");
  property p_txor; src == 6 && sel == 1 |=> pin1_out == $past(|(rx_pass & tx_port_selected));
  endproperty
  a_txor: assert property (p_txor) else $error("pass OR wrong");
  property p_line; src == 6 && sel == 3 |=> pin1_out == $past(tx_line_active); endproperty
  a_line: assert property (p_line) else $error("line activity not routed");
  property p_rsv; src == 5 || src == 7 |=> !pin1_out; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved source not low");
  property p_oe; 1 |=> pin1_oe_b == !$past(ctl_r[0]); endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  property p_rd; reg_read && reg_addr == 8'h11 |=> reg_rdata == $past(ctl_r); endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
endmodule
bind gpio_output_mux gpio_output_mux_checker #(.PORTS(PORTS)) gpio_output_mux_checker_inst (
  .clock, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_remote_pin,
  .rx_lock, .rx_pass, .tx_port_selected, .tx_line_active, .pin1_out, .pin1_oe_b);
`default_nettype wire

// [testbench/pin_observer.sv]
// Purpose: external logic watching pin 1
// Assumes: no pull resistor on the pin
// Notes: a released pin toggles, so a floating pin never looks stable
`timescale 1ns/1ps
`default_nettype none
module pin_observer (
  // clock and pin driver
  input wire logic clock,
  input wire logic pin1_out,
  input wire logic pin1_oe_b,
  // level seen on the wire
  output logic pin_level
);
  logic last_r = 1'b0;
  // undriven wire shows the inverse of its last level
  assign pin_level = pin1_oe_b ? ~last_r : pin1_out;
  always_ff @(posedge clock) last_r <= pin_level;
endmodule
`default_nettype wire

// [testbench/tb_gpio_output_mux.sv]
// Purpose: self-checking bench for the pin 1 output multiplexer
// Assumes: four receive ports, control register at 0x11
// Notes: sweeps every source and select code twice, inputs inverted between sweeps
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_output_mux;
  logic clock = 0, rst_b = 0, reg_write = 0, reg_read = 0, pin1_out, pin1_oe_b, pin_level;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ctl;
  logic [15:0] rx_remote_pin = 16'hA5C3;
  logic [3:0] rx_lock = 4'h4, rx_pass = 4'hE, rx_frame_valid = 4'h5, rx_line_valid = 4'h9;
  logic [3:0] rx_port_enabled = 4'h6, tx_port_selected = 4'h3;
  logic tx_frame_active = 1, tx_line_active = 0, tx_synchronized = 1, tx_interrupt = 1;
  logic frame_sync_pulse = 1;
  int n_fail = 0, samples_checked = 0;
  always #2 clock = ~clock;
  gpio_output_mux gpio_output_mux_inst (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .rx_remote_pin, .rx_lock, .rx_pass, .rx_frame_valid,
    .rx_line_valid, .rx_port_enabled, .tx_port_selected, .tx_frame_active, .tx_line_active,
    .tx_synchronized, .tx_interrupt, .frame_sync_pulse, .pin1_out, .pin1_oe_b);
  pin_observer pin_observer_inst (.clock, .pin1_out, .pin1_oe_b, .pin_level);
  // expected pin from the code table; empty port sets make AND low, reserved codes low
  function automatic logic exp_pin(input logic [2:0] s, input logic [2:0] k, input logic v);
    logic [7:0] rx, st, tx;
    rx = {rx_line_valid[s[1:0]], rx_frame_valid[s[1:0]], rx_pass[s[1:0]], rx_lock[s[1:0]],
      rx_remote_pin[4*s[1:0] +: 4]};
    st = {3'h0, frame_sync_pulse, &(rx_pass | ~rx_port_enabled) && |rx_port_enabled,
      &(rx_lock | ~rx_port_enabled) && |rx_port_enabled, |(rx_lock & rx_port_enabled), v};
    tx = {2'h0, tx_interrupt, tx_synchronized, tx_line_active, tx_frame_active,
      |(rx_pass & tx_port_selected), &(rx_pass | ~tx_port_selected) && |tx_port_selected};
    return s == 4 ? st[k] : s == 6 ? tx[k] : !s[2] && rx[k];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 0;
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset state, unmapped address, then full code sweeps and driver release
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1;
    @(negedge clock);
    chk({7'h0, pin1_oe_b}, 8'h01);
    rd(8'h11, 8'h00);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h00);
    rd(8'h11, 8'h00);
    $display("reset and decode test done");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 64; c++) begin
        ctl = {c[2:0], c[5:3], p[0], 1'b1};
        wr(8'h11, ctl);
        rd(8'h11, ctl);
        chk({6'h0, pin1_oe_b, pin_level}, {7'h0, exp_pin(ctl[4:2], ctl[7:5], p[0])});
      end
      $display("sweep %0d done", p);
      @(posedge clock);
      {rx_remote_pin, rx_lock, rx_pass} <= ~{rx_remote_pin, rx_lock, rx_pass};
      {rx_port_enabled, tx_port_selected} <= ~{rx_port_enabled, tx_port_selected};
      {rx_frame_valid, rx_line_valid} <= ~{rx_frame_valid, rx_line_valid};
      {tx_frame_active, tx_line_active, tx_synchronized, tx_interrupt, frame_sync_pulse} <=
        ~{tx_frame_active, tx_line_active, tx_synchronized, tx_interrupt, frame_sync_pulse};
    end
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h00);
    chk({7'h0, pin1_oe_b}, 8'h01);
    $display("driver release test done");
    // reset in mid-run must release the driver and clear the register
    wr(8'h11, 8'hE3);
    @(posedge clock);
    rst_b <= 0;
    @(posedge clock);
    rst_b <= 1;
    @(negedge clock);
    chk({7'h0, pin1_oe_b}, 8'h01);
    rd(8'h11, 8'h00);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
